// *** verilog/ccu_params.svh ***
// constants of the checksum unit: register offsets, field positions, reset values, buffer size
// assumes byte offsets within the unit, decoded from the low address bits
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

`define CCU_ADDR_BITS 5
`define CCU_OFF_DATA 5'h00
`define CCU_OFF_SPARE 5'h04
`define CCU_OFF_CTRL 5'h08
`define CCU_OFF_START 5'h10
`define CCU_OFF_GEN 5'h14

`define CCU_RST_DATA 32'hffff_ffff
`define CCU_RST_SPARE 8'h00
`define CCU_RST_START 32'hffff_ffff
`define CCU_RST_GEN 32'h04c1_1db7

`define CCU_CTRL_RESET_BIT 0
`define CCU_CTRL_GW_LSB 3
`define CCU_CTRL_GW_MSB 4
`define CCU_CTRL_IN_LSB 5
`define CCU_CTRL_IN_MSB 6
`define CCU_CTRL_OUT_BIT 7

`define CCU_FIFO_DEPTH 16
`define CCU_FIFO_WIDTH 34

`endif

// *** verilog/ccu_pkg.sv ***
// types shared by the checksum unit
// assumes ccu_params.svh carries the numeric constants
package ccu_pkg;
    typedef enum logic [1:0] {
        GW_32 = 2'b00,
        GW_16 = 2'b01,
        GW_8 = 2'b10,
        GW_7 = 2'b11
    } ccu_gen_width_type;

    typedef enum logic [1:0] {
        FLIP_NONE = 2'b00,
        FLIP_BYTE = 2'b01,
        FLIP_HALF = 2'b10,
        FLIP_WORD = 2'b11
    } ccu_flip_type;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10,
        SZ_BAD = 2'b11
    } ccu_size_type;

    typedef enum logic {
        ENG_IDLE = 1'b0,
        ENG_RUN = 1'b1
    } ccu_eng_state_type;
endpackage

// *** verilog/ccu_unit.sv ***
// checksum unit: ahb-lite slave, 16-entry input fifo and a byte-per-cycle checksum engine
// assumes one clock, synchronous active-high reset, hsel already decoded for the unit's window
`timescale 1ns/10ps
`include "ccu_params.svh"

// input buffer: width and depth shape the storage; valid/ready on both sides
module ccu_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; only pointers and count need a defined value
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// Notes on behaviour
// R1 - data register takes word, half, byte writes
// R2 - data write feeds engine; read returns result
// R3 - narrow widths use low-order bits both ways
// R4 - spare byte untouched by calculation reset
// R5 - control bit 7 reverses the result
// R6 - control 6:5 reverses input per byte/half/word
// R7 - control 4:3 selects 32/16/8/7-bit generator
// R8 - control bit 0 reloads start value
// R9 - bit 0 set only; hardware clears it
// R10 - start value at 0x10, resets all ones
// R11 - generator at 0x14, resets 0x04C11DB7
// R12 - software puts narrow generators in low bits
// R13 - software keeps reserved bits at reset
// R14 - four, two or one cycles per write
// R15 - start value write also loads data register
// R16 - input buffer takes writes without wait; the code adds wait states while the buffer is full or a reload is pending
// R17 - software changes generator only when idle
// R18 - msb-first shift, xor generator on feedback
module ccu_unit (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import ccu_pkg::*;

    // address-phase capture
    logic ap_valid_ff;
    logic ap_write_ff;
    logic [`CCU_ADDR_BITS-1:0] ap_addr_ff;
    logic [2:0] ap_size_ff;
    // registers
    logic [31:0] checksum_value_field_ff;
    logic [7:0] spare_byte_field_ff;
    logic output_bit_flip_ff;
    ccu_flip_type input_bit_flip_ff;
    ccu_gen_width_type generator_width_ff;
    logic [31:0] start_value_ff;
    logic [31:0] generator_coeff_field_ff;
    logic load_req_ff;
    // engine
    ccu_eng_state_type eng_state_ff;
    logic [31:0] shift_ff;
    logic [1:0] bytes_left_ff;
    // fifo wiring
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [`CCU_FIFO_WIDTH-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`CCU_FIFO_WIDTH-1:0] fifo_out_data;
    // data-phase decode
    logic dp_wr;
    logic dp_rd;
    logic dp_word;
    logic dp_data_wr;
    logic dp_data_rd;
    logic stall;
    logic engine_quiet;
    logic load_now;
    logic [31:0] first_word;
    ccu_size_type first_size;
    logic [31:0] flipped;
    logic [31:0] aligned;
    logic [31:0] result_view;
    logic [31:0] nxt_hrdata;

    // reverse all 32 bits
    function automatic logic [31:0] rev32(input logic [31:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31-i];
        end
        return r;
    endfunction

    // mask selecting the generator width's low bits
    function automatic logic [31:0] width_mask(input ccu_gen_width_type gw);
        logic [31:0] m;
        case (gw)
            GW_32: m = 32'hffff_ffff;
            GW_16: m = 32'h0000_ffff;
            GW_8: m = 32'h0000_00ff;
            GW_7: m = 32'h0000_007f;
            default: m = 32'hffff_ffff;
        endcase
        return m;
    endfunction

    // msb-first bitwise division over one byte
    function automatic logic [31:0] step8(input logic [31:0] c, input logic [7:0] b,
                                          input logic [31:0] generator_coeff_field, input ccu_gen_width_type gw);
        logic [31:0] r;
        logic fb;
        logic top;
        r = c;
        fb = 1'b0;
        top = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            case (gw)
                GW_32: top = r[31];
                GW_16: top = r[15];
                GW_8: top = r[7];
                GW_7: top = r[6];
                default: top = r[31];
            endcase
            fb = top ^ b[i];
            r = r << 1;
            if (fb) begin
                r = r ^ generator_coeff_field; // R18
            end
            r = r & width_mask(gw);
        end
        return r;
    endfunction

    // input reversal; a narrow write only reverses within what it carries
    function automatic logic [31:0] flip_in(input logic [31:0] d, input ccu_flip_type f,
                                            input ccu_size_type sz);
        logic [31:0] r;
        logic [31:0] w;
        r = d;
        w = rev32(d);
        case (f)
            FLIP_NONE: r = d;
            FLIP_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            FLIP_HALF: r = (sz == SZ_BYTE) ? {w[7:0], w[15:8], w[23:16], w[31:24]} : {w[15:0], w[31:16]};
            FLIP_WORD: begin
                case (sz)
                    SZ_BYTE: r = {24'h00_0000, w[31:24]};
                    SZ_HALF: r = {16'h0000, w[31:16]};
                    default: r = w;
                endcase
            end
            default: r = d;
        endcase
        return r;
    endfunction

    // address phase: latch every selected transfer while the bus is ready
    always_ff @(posedge clock) begin
        if (rst) begin
            ap_valid_ff <= 1'b0;
            ap_write_ff <= 1'b0;
            ap_addr_ff <= '0;
            ap_size_ff <= 3'h0;
        end else if (hready) begin
            ap_valid_ff <= hsel && htrans[1];
            ap_write_ff <= hwrite;
            ap_addr_ff <= haddr[`CCU_ADDR_BITS-1:0];
            ap_size_ff <= hsize;
        end
    end

    assign dp_wr = ap_valid_ff && ap_write_ff;
    assign dp_rd = ap_valid_ff && !ap_write_ff;
    assign dp_word = (ap_size_ff == 3'h2);
    // data register takes word, half-word and byte, right-aligned only
    assign dp_data_wr = dp_wr && (ap_addr_ff == `CCU_OFF_DATA) && (ap_size_ff <= 3'h2)
                        && (ap_addr_ff[1:0] == 2'b00); // R1
    assign dp_data_rd = dp_rd && (ap_addr_ff == `CCU_OFF_DATA);
    assign engine_quiet = (eng_state_ff == ENG_IDLE) && !fifo_out_valid;

    // a full buffer, or a pending reload, holds data writes so order is kept;
    // reads of the result wait for the engine so they never see a half-done value
    assign stall = (dp_data_wr && (!fifo_in_ready || load_req_ff))
                   || (dp_data_rd && (!engine_quiet || load_req_ff)); // R16
    assign hreadyout = !stall;
    assign hresp = 1'b0;

    // buffer entry: size in the top two bits, data below
    assign fifo_in_valid = dp_data_wr && !load_req_ff;
    assign fifo_in_data = {ap_size_ff[1:0], hwdata}; // R2

    ccu_fifo #(
        .WIDTH(`CCU_FIFO_WIDTH),
        .DEPTH(`CCU_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // spare byte: word writes only, never touched by the reload
    always_ff @(posedge clock) begin
        if (rst) begin
            spare_byte_field_ff <= `CCU_RST_SPARE;
        end else if (dp_wr && dp_word && ap_addr_ff == `CCU_OFF_SPARE) begin
            spare_byte_field_ff <= hwdata[7:0]; // R4
        end
    end

    // control fields, word writes only
    always_ff @(posedge clock) begin
        if (rst) begin
            output_bit_flip_ff <= 1'b0;
            input_bit_flip_ff <= FLIP_NONE;
            generator_width_ff <= GW_32;
        end else if (dp_wr && dp_word && ap_addr_ff == `CCU_OFF_CTRL) begin
            output_bit_flip_ff <= hwdata[`CCU_CTRL_OUT_BIT]; // R5
            input_bit_flip_ff <= ccu_flip_type'(hwdata[`CCU_CTRL_IN_MSB:`CCU_CTRL_IN_LSB]); // R6
            generator_width_ff <= ccu_gen_width_type'(hwdata[`CCU_CTRL_GW_MSB:`CCU_CTRL_GW_LSB]); // R7
        end
    end

    // start value and generator coefficients
    always_ff @(posedge clock) begin
        if (rst) begin
            start_value_ff <= `CCU_RST_START; // R10
            generator_coeff_field_ff <= `CCU_RST_GEN; // R11
        end else if (dp_wr && dp_word) begin
            if (ap_addr_ff == `CCU_OFF_START) begin
                start_value_ff <= hwdata; // R10
            end
            if (ap_addr_ff == `CCU_OFF_GEN) begin
                generator_coeff_field_ff <= hwdata; // R11
            end
        end
    end

    // reload request: set by a 1 in bit 0 or by a start-value write, cleared once done;
    // a new request in the clearing cycle wins so none is lost
    assign load_now = load_req_ff && engine_quiet;
    always_ff @(posedge clock) begin
        if (rst) begin
            load_req_ff <= 1'b0;
        end else if (dp_wr && dp_word && ap_addr_ff == `CCU_OFF_CTRL && hwdata[`CCU_CTRL_RESET_BIT]) begin
            load_req_ff <= 1'b1; // R9
        end else if (dp_wr && dp_word && ap_addr_ff == `CCU_OFF_START) begin
            load_req_ff <= 1'b1; // R15
        end else if (load_now) begin
            load_req_ff <= 1'b0; // R9
        end
    end

    // first word out of the buffer, reversed and left-aligned so the engine eats top bytes
    assign first_size = ccu_size_type'(fifo_out_data[33:32]);
    assign first_word = fifo_out_data[31:0];
    assign flipped = flip_in(first_word, input_bit_flip_ff, first_size); // R6
    always_comb begin
        case (first_size)
            SZ_BYTE: aligned = {flipped[7:0], 24'h00_0000}; // R3
            SZ_HALF: aligned = {flipped[15:0], 16'h0000}; // R3
            default: aligned = flipped;
        endcase
    end
    assign fifo_out_ready = (eng_state_ff == ENG_IDLE) && !load_req_ff;

    // engine: first byte in the pop cycle, one byte per cycle after, so 4/2/1 cycles
    always_ff @(posedge clock) begin
        if (rst) begin
            eng_state_ff <= ENG_IDLE;
            shift_ff <= 32'h0000_0000;
            bytes_left_ff <= 2'b00;
            checksum_value_field_ff <= `CCU_RST_DATA;
        end else begin
            case (eng_state_ff)
                ENG_IDLE: begin
                    if (load_now) begin
                        checksum_value_field_ff <= start_value_ff & width_mask(generator_width_ff); // R8
                    end else if (fifo_out_valid && fifo_out_ready) begin
                        checksum_value_field_ff <= step8(checksum_value_field_ff, aligned[31:24],
                                                         generator_coeff_field_ff, generator_width_ff); // R2
                        shift_ff <= {aligned[23:0], 8'h00};
                        if (first_size == SZ_WORD) begin
                            bytes_left_ff <= 2'b11; // R14
                            eng_state_ff <= ENG_RUN;
                        end else if (first_size == SZ_HALF) begin
                            bytes_left_ff <= 2'b01; // R14
                            eng_state_ff <= ENG_RUN;
                        end
                    end
                end
                ENG_RUN: begin
                    checksum_value_field_ff <= step8(checksum_value_field_ff, shift_ff[31:24],
                                                     generator_coeff_field_ff, generator_width_ff); // R18
                    shift_ff <= {shift_ff[23:0], 8'h00};
                    bytes_left_ff <= bytes_left_ff - 2'b01;
                    if (bytes_left_ff == 2'b01) begin
                        eng_state_ff <= ENG_IDLE; // R14
                    end
                end
                default: begin
                    eng_state_ff <= ENG_IDLE;
                end
            endcase
        end
    end

    // result view: narrow result stays low; reversal acts within the generator width
    always_comb begin
        case (generator_width_ff)
            GW_16: result_view = rev32(checksum_value_field_ff) >> 16;
            GW_8: result_view = rev32(checksum_value_field_ff) >> 24;
            GW_7: result_view = rev32(checksum_value_field_ff) >> 25;
            default: result_view = rev32(checksum_value_field_ff);
        endcase
        if (!output_bit_flip_ff) begin
            result_view = checksum_value_field_ff; // R5
        end
    end

    // read mux; unmapped offsets read as zero with an okay answer
    always_comb begin
        case (ap_addr_ff)
            `CCU_OFF_DATA: nxt_hrdata = result_view; // R2
            `CCU_OFF_SPARE: nxt_hrdata = {24'h00_0000, spare_byte_field_ff};
            `CCU_OFF_CTRL: nxt_hrdata = {24'h00_0000, output_bit_flip_ff, input_bit_flip_ff,
                                         generator_width_ff, 2'b00, load_req_ff};
            `CCU_OFF_START: nxt_hrdata = start_value_ff;
            `CCU_OFF_GEN: nxt_hrdata = generator_coeff_field_ff;
            default: nxt_hrdata = 32'h0000_0000;
        endcase
    end
    // only word reads of the other registers carry data; the data register allows any width
    assign hrdata = (dp_rd && (dp_word || ap_addr_ff == `CCU_OFF_DATA)) ? nxt_hrdata : 32'h0000_0000; // R1
endmodule

// *** dv/ccu_unit_monitor.sv ***
// checker for the checksum unit: bus timing and read-data relations seen at the top ports
// assumes it is bound onto ccu_unit and that hready mirrors hreadyout on a single-slave bus
`timescale 1ns/10ps
`include "ccu_params.svh"

module ccu_unit_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    logic acc;
    logic rd_ff;
    logic [6:0] quiet_ff;

    // an address phase is taken only with select, active transfer and bus ready
    assign acc = hsel && htrans[1] && hready;

    // read data phase tracker, held while the slave stretches the phase
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_ff <= 1'b0;
        end else if (hreadyout) begin
            rd_ff <= acc && !hwrite;
        end
    end

    // cycles since the last write; 70 is well past any single buffered word plus reload
    always_ff @(posedge clock) begin
        if (rst) begin
            quiet_ff <= 7'h7f;
        end else if (acc && hwrite) begin
            quiet_ff <= 7'h00;
        end else if (quiet_ff != 7'h7f) begin
            quiet_ff <= quiet_ff + 7'h01;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
    property p_resp_okay; hresp == 1'b0; endproperty
    a_reg_nowait: assert property (p_reg_nowait) else $error("wait state on a plain register");
    property p_reg_nowait; acc && haddr[4:0] != `CCU_OFF_DATA |=> hreadyout; endproperty
    a_narrow_zero: assert property (p_narrow_zero) else $error("narrow register read not zero");
    property p_narrow_zero;
        acc && !hwrite && haddr[4:0] != `CCU_OFF_DATA && hsize != 3'd2 |=> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_unmapped_zero;
        acc && !hwrite && haddr[4:0] inside {5'h0c, 5'h18, 5'h1c} |=> hrdata == 32'h0000_0000;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read phase");
    property p_idle_rdata; !rd_ff |-> hrdata == 32'h0000_0000; endproperty
    a_idle_read: assert property (p_idle_read) else $error("stall on read with idle engine");
    property p_idle_read; acc && !hwrite && haddr[4:0] == `CCU_OFF_DATA && quiet_ff >= 7'd70 |=> hreadyout; endproperty
    a_spare_upper: assert property (p_spare_upper) else $error("spare upper bits not zero");
    property p_spare_upper;
        acc && !hwrite && haddr[4:0] == `CCU_OFF_SPARE |=> hrdata[31:8] == 24'h00_0000;
    endproperty
    a_ctrl_resv: assert property (p_ctrl_resv) else $error("control reserved bits not zero");
    property p_ctrl_resv;
        acc && !hwrite && haddr[4:0] == `CCU_OFF_CTRL |=> hrdata[31:8] == 24'h00_0000 && hrdata[2:1] == 2'b00;
    endproperty
    a_read_bound: assert property (p_read_bound) else $error("read stall too long");
    property p_read_bound; acc && !hwrite |=> ##[0:100] hreadyout; endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("wait state on buffered write");
    property p_write_nowait; acc && hwrite && haddr[4:0] == `CCU_OFF_DATA && quiet_ff >= 7'd70 |=> hreadyout; endproperty
endmodule

// *** dv/crc_calc_unit_bench.sv ***
// self-checking bench for the checksum unit: register reset values, buffering, reload, all modes
// assumes ccu_unit is the only slave, so hready is looped back from hreadyout
`timescale 1ns/10ps
`include "ccu_params.svh"

module crc_calc_unit_bench;
    import ccu_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'd0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] m_crc = 32'hffff_ffff;
    logic [31:0] m_pol = 32'h04c1_1db7;
    logic [31:0] m_start = 32'hffff_ffff;
    int m_w = 32;
    logic [1:0] m_in = 2'b00;
    logic m_out = 1'b0;
    logic [31:0] rd;
    int stall_n = 0;

    // single slave: bus ready is this slave's own ready
    assign hready = hreadyout;

    initial forever #25 clock = ~clock;

    ccu_unit u_ccu_unit (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));

    task automatic close_out;
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // all tasks but wait_ready and check start and end right after a rising edge, so inputs change by nba there
    task automatic addr_phase(input logic [4:0] a, input logic wr, input logic [2:0] sz);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {27'h0, a};
        hwrite <= wr;
        hsize <= sz;
    endtask

    // ready is judged at the falling edge; the following rising edge ends the phase
    task automatic wait_ready;
        int n;
        n = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1 && n < 200) begin
            n++;
            @(negedge clock);
        end
        if (n >= 200) begin
            err_total++;
            $display("[FAIL] %0t slave never ready", $time);
        end
        stall_n = n;
    endtask

    task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [2:0] sz);
        addr_phase(a, 1'b1, sz);
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        @(posedge clock);
    endtask

    task automatic bus_read(input logic [4:0] a, input logic [2:0] sz, output logic [31:0] d);
        addr_phase(a, 1'b0, sz);
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        wait_ready();
        d = hrdata;
        @(posedge clock);
    endtask

    // reference checksum: optional input flip per chunk, then msb-first shift and xor
    function automatic void feed(input logic [31:0] d, input int nb);
        logic [31:0] x;
        logic [31:0] mk;
        logic fb;
        int c;
        c = (m_in == 2'b00) ? 1 : (m_in == 2'b01) ? 8 : (m_in == 2'b10) ? 16 : 32;
        if (c > nb) c = nb;
        x = d;
        for (int i = 0; i < nb; i++) x[(i / c) * c + c - 1 - i % c] = d[i];
        mk = (m_w == 32) ? 32'hffff_ffff : (32'h0000_0001 << m_w) - 32'h0000_0001;
        for (int i = nb - 1; i >= 0; i--) begin
            fb = m_crc[m_w - 1] ^ x[i];
            m_crc = (m_crc << 1) & mk;
            if (fb) m_crc = m_crc ^ (m_pol & mk);
        end
    endfunction

    // output flip stays inside the generator width
    function automatic logic [31:0] expect_out;
        logic [31:0] r;
        r = m_crc;
        if (m_out) begin
            r = 32'h0000_0000;
            for (int i = 0; i < m_w; i++) r[m_w - 1 - i] = m_crc[i];
        end
        return r;
    endfunction

    task automatic t_reset_values;
        bus_read(`CCU_OFF_DATA, 3'd2, rd);
        check(rd, `CCU_RST_DATA, "data reset");
        bus_read(`CCU_OFF_SPARE, 3'd2, rd);
        check(rd, {24'h0, `CCU_RST_SPARE}, "spare reset");
        bus_read(`CCU_OFF_CTRL, 3'd2, rd);
        check(rd, 32'h0000_0000, "control reset");
        bus_read(`CCU_OFF_START, 3'd2, rd);
        check(rd, `CCU_RST_START, "start reset");
        bus_read(`CCU_OFF_GEN, 3'd2, rd);
        check(rd, `CCU_RST_GEN, "generator reset");
        bus_read(5'h0c, 3'd2, rd);
        check(rd, 32'h0000_0000, "unmapped read");
        bus_read(`CCU_OFF_START, 3'd0, rd);
        check(rd, 32'h0000_0000, "byte read of start");
    endtask

    // two word writes back to back: neither data phase may be stretched
    task automatic t_pair;
        addr_phase(`CCU_OFF_DATA, 1'b1, 3'd2);
        @(posedge clock);
        hwdata <= 32'h1a2b_3c4d;
        @(negedge clock);
        check({31'h0, hreadyout}, 32'h1, "first write stalled");
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= 32'h5566_7788;
        @(negedge clock);
        check({31'h0, hreadyout}, 32'h1, "second write stalled");
        @(posedge clock);
        feed(32'h1a2b_3c4d, 32);
        feed(32'h5566_7788, 32);
        bus_read(`CCU_OFF_DATA, 3'd2, rd);
        check(rd, expect_out(), "two word result");
        time_one(3'd2, 32, 32'd3);
        time_one(3'd1, 16, 32'd1);
        time_one(3'd0, 8, 32'd0);
    endtask

    // read after a write waits the calc out, less the pop cycle
    task automatic time_one(input logic [2:0] sz, input int nb, input logic [31:0] exp_n);
        bus_write(`CCU_OFF_DATA, 32'h0000_00c3, sz);
        feed(32'h0000_00c3, nb);
        bus_read(`CCU_OFF_DATA, 3'd2, rd);
        check(stall_n, exp_n, "calc cycles");
    endtask

    task automatic t_reload;
        bus_write(`CCU_OFF_SPARE, 32'h0000_00a5, 3'd2);
        bus_write(`CCU_OFF_START, 32'h1234_5678, 3'd2);
        m_start = 32'h1234_5678;
        m_crc = m_start;
        bus_read(`CCU_OFF_DATA, 3'd2, rd);
        check(rd, m_start, "start write loads data");
        bus_write(`CCU_OFF_DATA, 32'hdead_be5a, 3'd0);
        feed(32'hdead_be5a, 8);
        bus_write(`CCU_OFF_CTRL, 32'h0000_0000, 3'd2);
        bus_read(`CCU_OFF_DATA, 3'd2, rd);
        check(rd, expect_out(), "byte result kept");
        bus_write(`CCU_OFF_CTRL, 32'h0000_0001, 3'd2);
        repeat (8) @(posedge clock);
        bus_read(`CCU_OFF_CTRL, 3'd2, rd);
        check(rd, 32'h0000_0000, "reset bit self clear");
        bus_read(`CCU_OFF_DATA, 3'd2, rd);
        check(rd, m_start, "reset reloads start");
        bus_read(`CCU_OFF_SPARE, 3'd2, rd);
        check(rd, 32'h0000_00a5, "spare survives reset");
        m_crc = m_start;
    endtask

    // every width with every input flip, output flip alternating, word+half+byte writes
    task automatic t_modes;
        logic [31:0] pt [4];
        int wt [4];
        pt = '{32'h04c1_1db7, 32'h0000_1021, 32'h0000_0007, 32'h0000_0009};
        wt = '{32, 16, 8, 7};
        for (int g = 0; g < 4; g++) begin
            for (int im = 0; im < 4; im++) begin
                m_w = wt[g];
                m_pol = pt[g];
                m_in = 2'(im);
                m_out = 1'(im) ^ 1'(g);
                bus_write(`CCU_OFF_GEN, m_pol, 3'd2);
                bus_write(`CCU_OFF_CTRL, {24'h0, m_out, m_in, 2'(g), 3'b001}, 3'd2);
                m_crc = (m_w == 32) ? m_start : m_start & ((32'h0000_0001 << m_w) - 32'h0000_0001);
                bus_write(`CCU_OFF_DATA, 32'h1a2b_3c4d, 3'd2);
                feed(32'h1a2b_3c4d, 32);
                bus_write(`CCU_OFF_DATA, 32'hffff_c3a5, 3'd1);
                feed(32'hffff_c3a5, 16);
                bus_write(`CCU_OFF_DATA, 32'h0000_0081, 3'd0);
                feed(32'h0000_0081, 8);
                bus_read(`CCU_OFF_DATA, 3'd2, rd);
                check(rd, expect_out(), "mode result");
                bus_read(`CCU_OFF_CTRL, 3'd2, rd);
                check(rd, {24'h0, m_out, m_in, 2'(g), 3'b000}, "control");
            end
        end
    endtask

    // the run needs well under 4000 cycles; this limit only cuts a hang short
    initial begin
        #(50 * 40000);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset_values();
        t_pair();
        t_reload();
        t_modes();
        close_out();
    end
endmodule

bind ccu_unit ccu_unit_monitor u_ccu_unit_monitor (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
